// File: common/rtc_defines.svh
// Purpose: register map, field positions, keys and timing of the RTC control block
// Assumes: byte-wide registers reached over the two-wire serial bus
// Notes: definitions only
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH

// Register offsets
`define ADDR_YEAR 8'h06
`define ADDR_CAL 8'h07
`define ADDR_TSW 8'h08
`define ADDR_TCFG 8'h09
`define ADDR_KEY1 8'h20
`define ADDR_KEY2 8'h21
`define ADDR_SPECIAL 8'h22

// Reset values
`define RST_YEAR 8'h00
`define RST_CAL 8'h80
`define RST_TSW 8'h90
`define RST_TCFG 8'hAA
`define RST_SPECIAL 8'h00
`define READ_ZERO 8'h00

// Unlock keys and charger code
`define KEY1_VAL 8'h5E
`define KEY2_VAL 8'hC7
`define CHG_CODE 4'h5

// Field positions
`define BIT_OUT 7
`define BIT_TEST 6
`define BIT_SIGN 5
`define CAL_MSB 4
`define BIT_SWB 5
`define BIT_FET 6
`define CODE_MSB 3
`define BIT_RATE 0

// Timing
`define CLK_HZ 10000000
`define OSC_HZ 32768
`define OSC_DIV ((`CLK_HZ) / (`OSC_HZ))
`define TEST_HZ 512
`define HALF_512_TICKS ((`OSC_HZ) / (`TEST_HZ) / 2)
`define SLOW_WINDOW 491520
`define FAST_WINDOW 245760
`define TICKS_PER_SEC 32768

// Serial bus slave address, arbitrary default
`define DEV_ADDR 7'h51

`endif

// File: common/rtc_pkg.sv
// Purpose: types for the RTC control block
// Assumes: constants come from rtc_defines.svh
// Notes: one packed struct holds all core state
package rtc_pkg;

   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_TXLOAD} bus_state_t;

   typedef struct packed {
      bus_state_t st;
      logic [2:0] bitn;
      logic [7:0] shreg;
      logic [1:0] kind;
      logic rd;
      logic [7:0] ptr;
      logic sda_oe;
      logic scl_d;
      logic sda_d;
      logic [7:0] year;
      logic [7:0] cal;
      logic [7:0] tsw;
      logic [7:0] tcfg;
      logic [7:0] special;
      logic key1_ok;
      logic unlocked;
      logic [8:0] div;
      logic [4:0] c512;
      logic sq512;
      logic [18:0] win;
      logic [4:0] pend;
      logic [14:0] half;
      logic sq1;
      logic alert;
      logic charge;
      logic fet;
      logic leap;
   } core_state_t;

endpackage

// File: logic/sync2.sv
// Purpose: two-stage synchroniser for asynchronous inputs
// Assumes: single clock, synchronous active-low reset
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_state_t;

   sync_state_t s_reg;
   sync_state_t s_next;

   // Shift through both stages
   always_comb
   begin
      s_next.s1 = d;
      s_next.s2 = s_reg.s1;
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign q = s_reg.s2;
endmodule

// File: logic/rtc_ctrl.sv
// Purpose: RTC alert/test output, calibration, trickle charger and unlock control
// Assumes: clk at 10 MHz; serial bus pins and backup flag arrive asynchronously
// Notes: oscillator ticks come from a divider of clk
// Summary of operation
// - Test off: alert pin follows output level
// - Output level 0 low, 1 high
// - Test on: square wave replaces level
// - Rate select: 0 gives 512 Hz, 1 gives 1 Hz
// - 512 Hz uncorrected; 1 Hz includes correction
// - Sign 0 slows, sign 1 speeds
// - Slowing drops N ticks per 491520
// - Speeding adds N ticks per 245760
// - Switch bit 0 open, 1 closed
// - Charge only while switch bit closed
// - FET bypass bit 0 off, 1 on
// - Charger active only for code 0x5
// - First key 0x5E, reads zero
// - Second key 0xC7, reads zero
// - Special register written only after both keys
// - Year divisible by four is leap
// - On backup: bus silent, counters run
`timescale 1ns/1ps
`include "rtc_defines.svh"
module rtc_ctrl import rtc_pkg::*; #(
   parameter int OSC_DIV = `OSC_DIV,
   parameter int SLOW_WINDOW = `SLOW_WINDOW,
   parameter int FAST_WINDOW = `FAST_WINDOW,
   parameter int TICKS_PER_SEC = `TICKS_PER_SEC,
   parameter logic [6:0] DEV_ADDR = `DEV_ADDR
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic on_backup,
   output logic alert,
   output logic charge_active,
   output logic charger_fet_on,
   output logic leap_year
);
   // Refuse settings the counters cannot hold
   if (OSC_DIV < 2 || OSC_DIV > 512 || SLOW_WINDOW > 524288 || FAST_WINDOW > 524288
       || SLOW_WINDOW < 64 || FAST_WINDOW < 64 || TICKS_PER_SEC > 32768 || TICKS_PER_SEC < 4)
   begin : g_bad_param
      $error("rtc_ctrl: parameter out of range");
   end

   localparam logic [8:0] DIV_LAST = 9'(OSC_DIV - 1);
   localparam logic [4:0] HALF_512_LAST = 5'(`HALF_512_TICKS - 1);
   localparam logic [18:0] SLOW_LAST = 19'(SLOW_WINDOW - 1);
   localparam logic [18:0] FAST_LAST = 19'(FAST_WINDOW - 1);
   localparam logic [15:0] HALF_SEC = 16'(TICKS_PER_SEC / 2);

   core_state_t s_reg;
   core_state_t s_next;
   logic [2:0] pins_sync;
   logic scl_s;
   logic sda_s;
   logic backup_s;
   logic osc_tick;
   logic [1:0] step;
   logic [15:0] half_sum;
   logic [7:0] rdata;
   logic [7:0] rx_byte;
   logic scl_rise;
   logic scl_fall;

   // Pins from outside pass two flops
   sync2 #(
      .W(3)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({scl, sda_in, on_backup}),
      .q(pins_sync)
   );

   assign scl_s = pins_sync[2];
   assign sda_s = pins_sync[1];
   assign backup_s = pins_sync[0];

   // Read data for the current pointer
   always_comb
   begin
      unique case (s_reg.ptr)
         `ADDR_YEAR: rdata = s_reg.year;
         `ADDR_CAL: rdata = s_reg.cal;
         `ADDR_TSW: rdata = s_reg.tsw;
         `ADDR_TCFG: rdata = s_reg.tcfg;
         `ADDR_SPECIAL: rdata = s_reg.special;
         default: rdata = `READ_ZERO; // Key registers read zero
      endcase
   end

   assign scl_rise = scl_s && !s_reg.scl_d;
   assign scl_fall = !scl_s && s_reg.scl_d;
   assign rx_byte = {s_reg.shreg[6:0], sda_s};
   assign osc_tick = (s_reg.div == DIV_LAST);

   // Next state of everything
   always_comb
   begin
      s_next = s_reg;
      step = 2'd0;
      half_sum = 16'd0;
      s_next.scl_d = scl_s;
      s_next.sda_d = sda_s;

      // Oscillator tick divider
      s_next.div = osc_tick ? 9'd0 : 9'(s_reg.div + 9'd1);

      // Raw 512 Hz square wave, no correction
      if (osc_tick)
      begin
         if (s_reg.c512 == HALF_512_LAST)
         begin
            s_next.c512 = 5'd0;
            s_next.sq512 = !s_reg.sq512;
         end
         else
            s_next.c512 = 5'(s_reg.c512 + 5'd1);
      end

      // Correction window, length set by sign
      if (osc_tick)
      begin
         // At or past the end, so a sign change never strands the count
         if (s_reg.win >= (s_reg.cal[`BIT_SIGN] ? FAST_LAST : SLOW_LAST))
         begin
            s_next.win = 19'd0;
            s_next.pend = s_reg.cal[`CAL_MSB:0];
         end
         else
            s_next.win = 19'(s_reg.win + 19'd1);
      end

      // Corrected tick weight: drop or double pending ticks
      if (osc_tick)
      begin
         if (s_reg.pend != 5'd0 && s_reg.win != 19'd0)
         begin
            s_next.pend = 5'(s_reg.pend - 5'd1);
            step = s_reg.cal[`BIT_SIGN] ? 2'd2 : 2'd0;
         end
         else
            step = 2'd1;
      end

      // Corrected 1 Hz square wave
      half_sum = 16'(s_reg.half) + 16'(step);
      if (half_sum >= HALF_SEC)
      begin
         s_next.half = 15'(half_sum - HALF_SEC);
         s_next.sq1 = !s_reg.sq1;
      end
      else
         s_next.half = 15'(half_sum);

      // Alert pin source
      if (s_reg.cal[`BIT_TEST])
         s_next.alert = s_reg.special[`BIT_RATE] ? s_reg.sq1 : s_reg.sq512;
      else
         s_next.alert = s_reg.cal[`BIT_OUT];

      // Trickle charger gating
      s_next.charge = s_reg.tsw[`BIT_SWB] && (s_reg.tcfg[`CODE_MSB:0] == `CHG_CODE);
      s_next.fet = s_reg.tcfg[`BIT_FET];

      // Leap year: tens odd adds two modulo four
      s_next.leap = (2'(s_reg.year[1:0] + {s_reg.year[4], 1'b0}) == 2'b00);

      // Serial bus slave
      if (backup_s)
      begin
         // Bus ignored on backup; counters above keep running
         s_next.st = ST_IDLE;
         s_next.sda_oe = 1'b0;
      end
      else if (scl_s && s_reg.scl_d && s_reg.sda_d && !sda_s)
      begin
         // Start or repeated start
         s_next.st = ST_RX;
         s_next.kind = 2'd0;
         s_next.bitn = 3'd0;
         s_next.sda_oe = 1'b0;
      end
      else if (scl_s && s_reg.scl_d && !s_reg.sda_d && sda_s)
      begin
         // Stop
         s_next.st = ST_IDLE;
         s_next.sda_oe = 1'b0;
      end
      else
      begin
         unique case (s_reg.st)
            ST_IDLE:
            begin
               s_next.sda_oe = 1'b0;
            end
            ST_RX:
            begin
               if (scl_rise)
               begin
                  s_next.shreg = rx_byte;
                  s_next.bitn = 3'(s_reg.bitn + 3'd1);
                  if (s_reg.bitn == 3'd7)
                  begin
                     s_next.st = ST_ACK;
                     if (s_reg.kind == 2'd0)
                     begin
                        s_next.rd = rx_byte[0];
                        if (rx_byte[7:1] != DEV_ADDR)
                           s_next.st = ST_IDLE;
                     end
                     else if (s_reg.kind == 2'd1)
                        s_next.ptr = rx_byte;
                     else
                     begin
                        s_next.ptr = 8'(s_reg.ptr + 8'd1);
                        s_next.key1_ok = 1'b0;
                        s_next.unlocked = 1'b0;
                        unique case (s_reg.ptr)
                           `ADDR_YEAR: s_next.year = rx_byte;
                           `ADDR_CAL: s_next.cal = rx_byte;
                           `ADDR_TSW: s_next.tsw = rx_byte;
                           `ADDR_TCFG: s_next.tcfg = rx_byte;
                           `ADDR_KEY1: s_next.key1_ok = (rx_byte == `KEY1_VAL);
                           `ADDR_KEY2:
                              s_next.unlocked = s_reg.key1_ok
                                 && (rx_byte == `KEY2_VAL);
                           `ADDR_SPECIAL:
                           begin
                              // One write per unlock
                              if (s_reg.unlocked)
                                 s_next.special = rx_byte;
                           end
                           default: s_next.key1_ok = 1'b0;
                        endcase
                     end
                  end
               end
            end
            ST_ACK:
            begin
               if (scl_fall)
               begin
                  if (!s_reg.sda_oe)
                     s_next.sda_oe = 1'b1;
                  else if (s_reg.rd && s_reg.kind == 2'd0)
                  begin
                     s_next.st = ST_TX;
                     s_next.shreg = rdata;
                     s_next.ptr = 8'(s_reg.ptr + 8'd1);
                     s_next.bitn = 3'd0;
                     s_next.sda_oe = !rdata[7];
                  end
                  else
                  begin
                     s_next.sda_oe = 1'b0;
                     s_next.st = ST_RX;
                     s_next.bitn = 3'd0;
                     s_next.kind = (s_reg.kind == 2'd0) ? 2'd1 : 2'd2;
                  end
               end
            end
            ST_TX:
            begin
               if (scl_rise)
               begin
                  s_next.bitn = 3'(s_reg.bitn + 3'd1);
                  if (s_reg.bitn == 3'd7)
                     s_next.st = ST_TXACK;
               end
               else if (scl_fall)
               begin
                  s_next.shreg = {s_reg.shreg[6:0], 1'b0};
                  s_next.sda_oe = !s_reg.shreg[6];
               end
            end
            ST_TXACK:
            begin
               if (scl_fall)
                  s_next.sda_oe = 1'b0;
               else if (scl_rise)
                  s_next.st = sda_s ? ST_IDLE : ST_TXLOAD;
            end
            ST_TXLOAD:
            begin
               if (scl_fall)
               begin
                  s_next.st = ST_TX;
                  s_next.shreg = rdata;
                  s_next.ptr = 8'(s_reg.ptr + 8'd1);
                  s_next.bitn = 3'd0;
                  s_next.sda_oe = !rdata[7];
               end
            end
            default:
            begin
               s_next.st = ST_IDLE;
               s_next.sda_oe = 1'b0;
            end
         endcase
      end
   end

   // State register with documented reset values
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s_reg <= '0;
         s_reg.st <= ST_IDLE;
         s_reg.year <= `RST_YEAR;
         s_reg.cal <= `RST_CAL;
         s_reg.tsw <= `RST_TSW;
         s_reg.tcfg <= `RST_TCFG;
         s_reg.special <= `RST_SPECIAL;
         s_reg.alert <= 1'b1;
      end
      else
         s_reg <= s_next;
   end

   // Outputs from flops; open-drain data only pulls low
   assign sda_out = 1'b0;
   assign sda_oe = s_reg.sda_oe;
   assign alert = s_reg.alert;
   assign charge_active = s_reg.charge;
   assign charger_fet_on = s_reg.fet;
   assign leap_year = s_reg.leap;

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   property p_alert_level;
      !s_reg.cal[`BIT_TEST] |=> (alert == $past(s_reg.cal[`BIT_OUT]));
   endproperty
   a_alert_level: assert property (p_alert_level)
      else $error("alert does not follow output level");

   property p_alert_512;
      (s_reg.cal[`BIT_TEST] && !s_reg.special[`BIT_RATE]) |=> (alert == $past(s_reg.sq512));
   endproperty
   a_alert_512: assert property (p_alert_512)
      else $error("alert is not the 512 Hz wave");

   property p_alert_1hz;
      (s_reg.cal[`BIT_TEST] && s_reg.special[`BIT_RATE]) |=> (alert == $past(s_reg.sq1));
   endproperty
   a_alert_1hz: assert property (p_alert_1hz)
      else $error("alert is not the 1 Hz wave");

   property p_raw_512;
      (osc_tick && s_reg.c512 == HALF_512_LAST) |=> (s_reg.sq512 != $past(s_reg.sq512));
   endproperty
   a_raw_512: assert property (p_raw_512)
      else $error("512 Hz wave missed its toggle");

   property p_slow_drop;
      (osc_tick && s_reg.pend != 5'd0 && s_reg.win != 19'd0 && !s_reg.cal[`BIT_SIGN])
         |=> ($stable(s_reg.half) && $stable(s_reg.sq1));
   endproperty
   a_slow_drop: assert property (p_slow_drop)
      else $error("slowing correction did not drop a tick");

   property p_fast_add;
      (osc_tick && s_reg.pend != 5'd0 && s_reg.win != 19'd0 && s_reg.cal[`BIT_SIGN])
         |=> (s_reg.half == 15'($past(s_reg.half) + 15'd2) || $changed(s_reg.sq1));
   endproperty
   a_fast_add: assert property (p_fast_add)
      else $error("speeding correction did not add a tick");

   property p_charge;
      ##1 (charge_active == $past(s_reg.tsw[`BIT_SWB]
         && s_reg.tcfg[`CODE_MSB:0] == `CHG_CODE));
   endproperty
   a_charge: assert property (p_charge)
      else $error("charger state wrong");

   property p_fet;
      $changed(s_reg.tcfg[`BIT_FET]) |=> (charger_fet_on == $past(s_reg.tcfg[`BIT_FET]));
   endproperty
   a_fet: assert property (p_fet)
      else $error("FET does not follow bypass bit");

   property p_key_read;
      (s_reg.ptr == `ADDR_KEY1 || s_reg.ptr == `ADDR_KEY2) |-> (rdata == `READ_ZERO);
   endproperty
   a_key_read: assert property (p_key_read)
      else $error("key register read non-zero");

   property p_special_locked;
      $changed(s_reg.special) |-> ($past(s_reg.unlocked) && !s_reg.unlocked);
   endproperty
   a_special_locked: assert property (p_special_locked)
      else $error("special register written while locked");

   property p_unlock_order;
      $rose(s_reg.unlocked) |-> ($past(s_reg.key1_ok) && $past(s_reg.ptr) == `ADDR_KEY2);
   endproperty
   a_unlock_order: assert property (p_unlock_order)
      else $error("unlock without first key");

   property p_backup_quiet;
      backup_s |=> (!sda_oe && s_reg.st == ST_IDLE);
   endproperty
   a_backup_quiet: assert property (p_backup_quiet)
      else $error("bus driven on backup");

   property p_leap;
      ($past(s_reg.year) == 8'h96) |-> leap_year;
   endproperty
   a_leap: assert property (p_leap)
      else $error("year 96 not leap");

   c_special_write: cover property ($changed(s_reg.special));
   c_1hz_out: cover property (s_reg.cal[`BIT_TEST] && s_reg.special[`BIT_RATE]
      ##1 $changed(alert));
   c_charge_on: cover property ($rose(charge_active));
   c_read_byte: cover property (s_reg.st == ST_TX ##1 s_reg.st == ST_TXACK);
endmodule

// File: dv/i2c_host_model.sv
// Purpose: Serial bus host model for the RTC control block
// Assumes: Open-drain data line resolved by the bench, pull-up to 1
// Notes: Half bit 4 clk; scl idles high between frames
`timescale 1ns/1ps
`include "rtc_defines.svh"
module i2c_host_model #(
   parameter logic [6:0] ADDR = `DEV_ADDR
) (
   input wire logic clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_pull
);
   logic [7:0] rx;

   // Idle bus at time zero
   initial
   begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // Wait n clocks, then step off the edge
   task automatic hc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Start or repeated start, leaves scl low
   task automatic start_c();
      sda_pull = 1'b0;
      hc(4);
      scl = 1'b1;
      hc(4);
      sda_pull = 1'b1;
      hc(4);
      scl = 1'b0;
   endtask

   // One bit; data changes only while scl is low
   task automatic bit_c(input logic b, output logic s);
      hc(1);
      sda_pull = !b;
      hc(3);
      scl = 1'b1;
      hc(3);
      s = sda_line;
      hc(1);
      scl = 1'b0;
   endtask

   // Byte MSB first; ninth bit released, so a read ends with no ack
   task automatic byte_c(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_c(d[i], s);
         rx[i] = s;
      end
      bit_c(1'b1, s);
      ack = !s;
   endtask

   // Stop: data rises while scl high
   task automatic stop_c();
      hc(1);
      sda_pull = 1'b1;
      hc(3);
      scl = 1'b1;
      hc(4);
      sda_pull = 1'b0;
      hc(4);
   endtask

   // Register write, ok when all three bytes acked
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
      logic k0, k1, k2;
      start_c();
      byte_c({ADDR, 1'b0}, k0);
      byte_c(a, k1);
      byte_c(d, k2);
      stop_c();
      ok = k0 & k1 & k2;
   endtask

   // Register read through a repeated start
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      logic k0, k1, k2, k3;
      start_c();
      byte_c({ADDR, 1'b0}, k0);
      byte_c(a, k1);
      start_c();
      byte_c({ADDR, 1'b1}, k2);
      byte_c(8'hFF, k3);
      stop_c();
      d = rx;
      ok = k0 & k1 & k2;
   endtask
endmodule

// File: dv/rtc_ctrl_bench.sv
// Purpose: Self-checking bench for the RTC control block
// Assumes: Shortened oscillator divider and windows
// Notes: Rates are checked by counting alert toggles
`timescale 1ns/1ps
`include "rtc_defines.svh"
module rtc_ctrl_bench;
   localparam int DIV = 2;
   localparam int TPS = 128;
   localparam int SLW = 256;
   localparam int FSW = 128;
   localparam int WIN = 8192;
   localparam logic [15:0] RST_TAB [7] = '{16'h0780, 16'h0890, 16'h09AA,
      16'h2000, 16'h2100, 16'h2200, 16'h3000};
   localparam logic [15:0] LEAP_TAB [6] = '{16'h2401, 16'h2300, 16'h1000,
      16'h0001, 16'h9601, 16'h9800};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic on_backup = 1'b0;
   logic scl, sda_pull, sda_out, sda_oe, alert, charge_active, charger_fet_on, leap_year;
   logic sda_line;
   logic ok;
   logic [7:0] rv;
   int err_total = 0;
   int cmp_count = 0;
   int n;

   // Clock and open-drain data line with pull-up
   always #50 clk = ~clk;
   assign sda_line = (sda_oe ? sda_out : 1'b1) & !sda_pull;

   rtc_ctrl #(.OSC_DIV(DIV), .SLOW_WINDOW(SLW), .FAST_WINDOW(FSW),
      .TICKS_PER_SEC(TPS)) u_rtc_ctrl (.clk(clk), .rst_n(rst_n), .scl(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .on_backup(on_backup),
      .alert(alert), .charge_active(charge_active), .charger_fet_on(charger_fet_on),
      .leap_year(leap_year));

   i2c_host_model u_i2c_host_model (.clk(clk), .sda_line(sda_line), .scl(scl),
      .sda_pull(sda_pull));

   // Compare helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value t=%0t got 0x%h exp 0x%h", $time, got, exp);
      end
   endtask
   task automatic near(input int got, input int exp);
      cmp_count++;
      if (got < exp - 2 || got > exp + 2)
      begin
         err_total++;
         $display("wrong value t=%0t got 0x%h exp 0x%h", $time, got, exp);
      end
   endtask

   // Register access through the host model
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      u_i2c_host_model.wr(a, d, ok);
      chk(8'(ok), 8'h01);
   endtask
   task automatic r(input logic [7:0] a, input logic [7:0] e);
      u_i2c_host_model.rd(a, rv, ok);
      chk(8'(ok), 8'h01);
      chk(rv, e);
   endtask
   task automatic unlock_wr(input logic [7:0] d);
      w(`ADDR_KEY1, `KEY1_VAL);
      w(`ADDR_KEY2, `KEY2_VAL);
      w(`ADDR_SPECIAL, d);
   endtask

   // Alert toggles over a bounded span
   task automatic toggles(input int cyc, output int cnt);
      logic prev;
      cnt = 0;
      prev = alert;
      repeat (cyc)
      begin
         @(posedge clk);
         #1;
         if (alert !== prev)
            cnt++;
         prev = alert;
      end
   endtask

   // Expected 1 Hz toggles for a span, window and correction
   function automatic int exp1(input int win, input int nc, input bit fast);
      int t;
      t = WIN / DIV;
      t = fast ? t + (t / win) * nc : t - (t / win) * nc;
      return t / (TPS / 2);
   endfunction

   // Verdict and end of run
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Watchdog
   initial
   begin
      repeat (90000) @(posedge clk);
      err_total++;
      summarize();
   end

   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      #1;
      rst_n = 1'b1;
      u_i2c_host_model.hc(4);
      chk(8'({alert, charge_active, charger_fet_on}), 8'h04);
      foreach (RST_TAB[i])
         r(RST_TAB[i][15:8], RST_TAB[i][7:0]);
      w(`ADDR_CAL, 8'h00);
      chk(8'(alert), 8'h00);
      w(`ADDR_CAL, 8'h80);
      chk(8'(alert), 8'h01);
      w(`ADDR_TSW, 8'h20);
      for (int c = 0; c < 16; c++)
      begin
         w(`ADDR_TCFG, 8'(c));
         chk(8'(charge_active), 8'(c == 5));
      end
      w(`ADDR_TCFG, 8'h45);
      chk(8'({charge_active, charger_fet_on}), 8'h03);
      w(`ADDR_TSW, 8'h00);
      chk(8'({charge_active, charger_fet_on}), 8'h01);
      w(`ADDR_SPECIAL, 8'h01);
      r(`ADDR_SPECIAL, 8'h00);
      unlock_wr(8'h01);
      r(`ADDR_SPECIAL, 8'h01);
      w(`ADDR_SPECIAL, 8'h00);
      r(`ADDR_SPECIAL, 8'h01);
      w(`ADDR_KEY1, `KEY1_VAL);
      w(`ADDR_CAL, 8'h80);
      w(`ADDR_KEY2, `KEY2_VAL);
      w(`ADDR_SPECIAL, 8'h00);
      r(`ADDR_SPECIAL, 8'h01);
      w(`ADDR_KEY1, 8'h5F);
      w(`ADDR_KEY2, `KEY2_VAL);
      w(`ADDR_SPECIAL, 8'h00);
      r(`ADDR_SPECIAL, 8'h01);
      r(`ADDR_KEY1, 8'h00);
      r(`ADDR_KEY2, 8'h00);
      foreach (LEAP_TAB[i])
      begin
         w(`ADDR_YEAR, LEAP_TAB[i][15:8]);
         chk(8'(leap_year), LEAP_TAB[i][7:0]);
      end
      w(`ADDR_CAL, 8'h40);
      toggles(WIN, n);
      near(n, exp1(SLW, 0, 1'b0));
      w(`ADDR_CAL, 8'h5F);
      toggles(WIN, n);
      near(n, exp1(SLW, 31, 1'b0));
      w(`ADDR_CAL, 8'h7F);
      toggles(WIN, n);
      near(n, exp1(FSW, 31, 1'b1));
      unlock_wr(8'h00);
      w(`ADDR_CAL, 8'h5F);
      toggles(WIN, n);
      near(n, WIN / DIV / `HALF_512_TICKS);
      on_backup = 1'b1;
      u_i2c_host_model.hc(4);
      u_i2c_host_model.wr(`ADDR_CAL, 8'h80, ok);
      chk(8'(ok), 8'h00);
      toggles(WIN / 4, n);
      near(n, WIN / 4 / DIV / `HALF_512_TICKS);
      on_backup = 1'b0;
      u_i2c_host_model.hc(TPS * DIV);
      r(`ADDR_CAL, 8'h5F);
      summarize();
   end
endmodule
